// ---- common/icu_pkg.sv ----
// Package with register map, field layouts and encodings of the input capture unit
package icu_pkg;

    localparam int ICU_ADDR_W = 4;
    localparam logic [ICU_ADDR_W-1:0] ICU_OFS_CTRL_ONE = 4'h0;
    localparam logic [ICU_ADDR_W-1:0] ICU_OFS_CTRL_TWO = 4'h4;
    localparam logic [ICU_ADDR_W-1:0] ICU_OFS_FIFO = 4'h8;
    localparam logic [ICU_ADDR_W-1:0] ICU_OFS_COUNTER = 4'hC;

    localparam int ICU_FIFO_DEPTH = 4;
    localparam int ICU_PTR_W = 2;
    localparam logic [3:0] ICU_DIV16_LAST = 4'hF;
    localparam logic [3:0] ICU_DIV4_LAST = 4'h3;
    localparam logic [15:0] ICU_COUNT_MAX = 16'hFFFF;

    typedef enum logic [2:0] {
        ICU_MODE_OFF = 3'b000,
        ICU_MODE_EVERY_EDGE = 3'b001,
        ICU_MODE_FALL = 3'b010,
        ICU_MODE_RISE = 3'b011,
        ICU_MODE_RISE_DIV4 = 3'b100,
        ICU_MODE_RISE_DIV16 = 3'b101,
        ICU_MODE_UNUSED = 3'b110,
        ICU_MODE_WAKE = 3'b111
    } icu_mode_t;

    typedef enum logic [2:0] {
        ICU_TB_TIMER3 = 3'b000,
        ICU_TB_TIMER2 = 3'b001,
        ICU_TB_TIMER4 = 3'b010,
        ICU_TB_TIMER5 = 3'b011,
        ICU_TB_TIMER1 = 3'b100,
        ICU_TB_RSVD_5 = 3'b101,
        ICU_TB_RSVD_6 = 3'b110,
        ICU_TB_SYSCLK = 3'b111
    } icu_tbase_t;

    // Index of each time base tick in the tick vector
    localparam int ICU_TICK_TIMER1 = 0;
    localparam int ICU_TICK_TIMER2 = 1;
    localparam int ICU_TICK_TIMER3 = 2;
    localparam int ICU_TICK_TIMER4 = 3;
    localparam int ICU_TICK_TIMER5 = 4;

    localparam logic [4:0] ICU_SYNC_NONE = 5'b00000;
    localparam logic [4:0] ICU_SYNC_RSVD_A = 5'b10000;
    localparam logic [4:0] ICU_SYNC_RSVD_B = 5'b10001;
    localparam logic [4:0] ICU_SYNC_RSVD_C = 5'b11111;

    // Control one: [13] halt, [12:10] time base, [6:5] rate, [4] ovf, [3] not empty, [2:0] mode
    typedef struct packed {
        logic [1:0] rsvd_15_14;
        logic halt_in_idle;
        logic [2:0] time_base_select;
        logic [2:0] rsvd_9_7;
        logic [1:0] captures_per_interrupt;
        logic capture_overflow_flag;
        logic buffer_not_empty_flag;
        logic [2:0] capture_mode_select;
    } icu_ctrl_one_t;

    // Control two: [8] cascade, [7] trigger, [6] trigger status, [4:0] source
    typedef struct packed {
        logic [6:0] rsvd_15_9;
        logic cascade_enable;
        logic trigger_not_sync_select;
        logic trigger_status;
        logic rsvd_5;
        logic [4:0] sync_source_select;
    } icu_ctrl_two_t;

    localparam logic [15:0] ICU_CTRL_ONE_RESET = 16'h0000;
    localparam logic [15:0] ICU_CTRL_TWO_RESET = 16'h000D;
    localparam logic [15:0] ICU_CTRL_ONE_WMASK = 16'h3C67;
    localparam logic [15:0] ICU_CTRL_TWO_WMASK = 16'h01DF;

    // Signals exchanged between the two channels of a cascaded pair
    typedef struct packed {
        logic cascade_enable;
        logic capture;
        logic wrap;
        logic counter_clear;
    } icu_pair_t;

endpackage

// ---- hdl/icu_input_capture_unit.sv ----
// Input capture channel with Wishbone register slave, 4-entry FIFO and cascade link
// Behaviour
// RULE_01 - Mode 011 rising, 010 falling, 001 every edge captures.
// RULE_02 - Mode 101 every sixteenth rising edge, 100 every fourth.
// RULE_03 - Mode 000 off; unused 110 disabled too.
// RULE_04 - Mode 111 only wakes on rising edge in sleep or idle.
// RULE_05 - Rate 00..11 interrupts after one to four captures.
// RULE_06 - Every-edge mode ignores the rate field.
// RULE_07 - Read-only not-empty flag; clears when all read.
// RULE_08 - Read-only overflow flag.
// RULE_09 - Halt-in-idle stops the channel during idle.
// RULE_10 - Time base 111 clock; 100,011,010,001,000 timers 1,5,4,2,3.
// RULE_11 - Cascade enable in both neighbours makes one 32-bit channel.
// RULE_12 - Trigger select: set trigger, clear synchronous.
// RULE_13 - Trigger status set by hardware or software; clear holds counter.
// RULE_14 - Source 00000 none; reserved codes give no event.
// RULE_15 - Comparator, converter, charge-time codes only as triggers; the code also accepts them in synchronous mode.
// RULE_16 - A channel is never its own trigger source.
// RULE_17 - Software empties the FIFO before configuring.
// RULE_18 - Synchronous channel held cleared until its source fires.
// RULE_19 - Even channel set up first, same selections in both.
// RULE_20 - Even channel runs synchronously with the odd.
// RULE_21 - Odd channel's rate, trigger and mode govern a pair.
// RULE_22 - 32-bit value: odd buffer low, even buffer high.
// RULE_23 - Counter counts up, wraps to zero, pushed on capture.
// RULE_24 - Sync event clears counter; trigger mode waits.
// RULE_25 - Source 00000 with trigger set waits for software status.
// RULE_26 - Odd counter wrap increments the even counter.
// RULE_27 - Four-entry FIFO; capture when full sets overflow, cleared when off.
//
// The implementer's own choices: the address map and the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
module icu_input_capture_unit
    import icu_pkg::*;
(
    input wire logic clk_in, // 100 MHz system clock
    input wire logic rst_b_in, // Asynchronous reset, active low
    input wire logic wb_cyc_in, // Wishbone cycle
    input wire logic wb_stb_in, // Wishbone strobe
    input wire logic wb_we_in, // Wishbone write enable
    input wire logic [ICU_ADDR_W-1:0] wb_adr_in, // Wishbone byte address
    input wire logic [3:0] wb_sel_in, // Wishbone byte selects
    input wire logic [31:0] wb_dat_in, // Wishbone write data
    output logic [31:0] wb_dat_out, // Wishbone read data
    output logic wb_ack_out, // Wishbone acknowledge
    input wire logic capture_input_pin, // External pulse input
    input wire logic [4:0] timebase_tick_in, // Timer 1..5 count ticks
    input wire logic [31:0] sync_events_in, // Source event pulses, indexed by code
    input wire logic cpu_idle_in, // Processor idle
    input wire logic cpu_sleep_in, // Device sleep
    input wire logic upper_half_in, // This channel is the even (upper) one
    input wire icu_pair_t pair_in, // From the neighbour channel
    output icu_pair_t pair_out, // To the neighbour channel
    output logic capture_irq_out, // Interrupt event pulse
    output logic wake_out // Wake event pulse
);

    icu_ctrl_one_t ctrl_one_r;
    icu_ctrl_two_t ctrl_two_r;
    logic wb_ack_r;
    logic [31:0] wb_dat_r;
    logic pin_prev_r;
    logic [3:0] presc_r;
    logic [1:0] irq_cnt_r;
    logic [15:0] counter_r;
    logic sync_seen_r;
    logic [15:0] fifo_mem_r [ICU_FIFO_DEPTH];
    logic [ICU_PTR_W-1:0] wr_ptr_r;
    logic [ICU_PTR_W-1:0] rd_ptr_r;
    logic [ICU_PTR_W:0] fill_r;
    logic ovf_r;
    logic trig_r;
    logic irq_r;
    logic wake_r;

    logic bus_req;
    logic wr_ctrl_one;
    logic wr_ctrl_two;
    logic rd_fifo;
    logic [15:0] wmask;
    icu_mode_t mode;
    logic cascaded;
    logic upper;
    logic halted;
    logic active;
    logic rise;
    logic fall;
    logic edge_hit;
    logic capture;
    logic fifo_full;
    logic fifo_empty;
    logic push;
    logic pop;
    logic tick;
    logic src_reserved;
    logic src_event;
    logic trig_mode;
    logic sync_mode;
    logic hold_clear;
    logic sync_reset;
    logic count_en;
    logic wrap;
    logic irq_fire;
    logic [15:0] ctrl_one_rd;
    logic [15:0] ctrl_two_rd;

    // Bus decode; one wait state, ack drops the cycle after it is given
    assign bus_req = wb_cyc_in & wb_stb_in & ~wb_ack_r;
    assign wr_ctrl_one = bus_req & wb_we_in & (wb_adr_in == ICU_OFS_CTRL_ONE);
    assign wr_ctrl_two = bus_req & wb_we_in & (wb_adr_in == ICU_OFS_CTRL_TWO);
    assign rd_fifo = bus_req & ~wb_we_in & (wb_adr_in == ICU_OFS_FIFO);
    assign wmask = {{8{wb_sel_in[1]}}, {8{wb_sel_in[0]}}};

    assign mode = icu_mode_t'(ctrl_one_r.capture_mode_select);
    assign cascaded = ctrl_two_r.cascade_enable & pair_in.cascade_enable; // RULE_11
    assign upper = cascaded & upper_half_in;
    assign halted = ctrl_one_r.halt_in_idle & cpu_idle_in; // RULE_09

    // Channel runs unless off, unused, wake-only or halted in idle
    always_comb begin
        case (mode)
            ICU_MODE_OFF: active = 1'b0; // RULE_03
            ICU_MODE_UNUSED: active = 1'b0; // RULE_03
            ICU_MODE_WAKE: active = 1'b0; // RULE_04
            ICU_MODE_EVERY_EDGE: active = ~halted;
            ICU_MODE_FALL: active = ~halted;
            ICU_MODE_RISE: active = ~halted;
            ICU_MODE_RISE_DIV4: active = ~halted;
            ICU_MODE_RISE_DIV16: active = ~halted;
            default: active = 1'b0;
        endcase
    end

    assign rise = capture_input_pin & ~pin_prev_r;
    assign fall = ~capture_input_pin & pin_prev_r;

    always_comb begin
        case (mode)
            ICU_MODE_EVERY_EDGE: edge_hit = rise | fall; // RULE_01
            ICU_MODE_FALL: edge_hit = fall; // RULE_01
            ICU_MODE_RISE: edge_hit = rise; // RULE_01
            ICU_MODE_RISE_DIV4: edge_hit = rise & (presc_r[1:0] == ICU_DIV4_LAST[1:0]); // RULE_02
            ICU_MODE_RISE_DIV16: edge_hit = rise & (presc_r == ICU_DIV16_LAST); // RULE_02
            default: edge_hit = 1'b0;
        endcase
    end

    // The upper half follows the odd channel's capture decision
    assign capture = active & ~hold_clear & (upper ? pair_in.capture : edge_hit); // RULE_21

    // Time base selection
    always_comb begin
        case (icu_tbase_t'(ctrl_one_r.time_base_select))
            ICU_TB_SYSCLK: tick = 1'b1; // RULE_10
            ICU_TB_TIMER1: tick = timebase_tick_in[ICU_TICK_TIMER1]; // RULE_10
            ICU_TB_TIMER5: tick = timebase_tick_in[ICU_TICK_TIMER5]; // RULE_10
            ICU_TB_TIMER4: tick = timebase_tick_in[ICU_TICK_TIMER4]; // RULE_10
            ICU_TB_TIMER2: tick = timebase_tick_in[ICU_TICK_TIMER2]; // RULE_10
            ICU_TB_TIMER3: tick = timebase_tick_in[ICU_TICK_TIMER3]; // RULE_10
            default: tick = 1'b0;
        endcase
    end

    // Reserved source codes never produce an event
    assign src_reserved = (ctrl_two_r.sync_source_select == ICU_SYNC_NONE)
        | (ctrl_two_r.sync_source_select == ICU_SYNC_RSVD_A)
        | (ctrl_two_r.sync_source_select == ICU_SYNC_RSVD_B)
        | (ctrl_two_r.sync_source_select == ICU_SYNC_RSVD_C); // RULE_14
    assign src_event = ~src_reserved & sync_events_in[ctrl_two_r.sync_source_select]; // RULE_14

    // Upper half always runs synchronously with the odd channel
    assign trig_mode = ~upper & ctrl_two_r.trigger_not_sync_select; // RULE_12 RULE_20
    assign sync_mode = ~upper & ~ctrl_two_r.trigger_not_sync_select & ~src_reserved; // RULE_12
    assign hold_clear = upper ? pair_in.counter_clear
        : ((trig_mode & ~trig_r) | (sync_mode & ~sync_seen_r)); // RULE_13 RULE_18
    assign sync_reset = upper ? 1'b0 : (sync_mode & src_event); // RULE_24
    assign count_en = active & ~hold_clear & (upper ? pair_in.wrap : tick); // RULE_26
    assign wrap = count_en & (counter_r == ICU_COUNT_MAX);

    assign fifo_full = (fill_r == ICU_PTR_W'(0) + (ICU_PTR_W+1)'(ICU_FIFO_DEPTH));
    assign fifo_empty = (fill_r == '0);
    assign push = capture & ~fifo_full;
    assign pop = rd_fifo & ~fifo_empty;

    // Every-edge mode interrupts on each capture; the upper half never interrupts
    assign irq_fire = capture & ~upper
        & ((mode == ICU_MODE_EVERY_EDGE)
        | (irq_cnt_r == ctrl_one_r.captures_per_interrupt)); // RULE_05 RULE_06 RULE_21

    always_comb begin
        ctrl_one_rd = ctrl_one_r;
        ctrl_one_rd[15:14] = '0;
        ctrl_one_rd[9:7] = '0;
        ctrl_one_rd[4] = ovf_r; // RULE_08
        ctrl_one_rd[3] = ~fifo_empty; // RULE_07
        ctrl_two_rd = ctrl_two_r;
        ctrl_two_rd[15:9] = '0;
        ctrl_two_rd[5] = 1'b0;
        ctrl_two_rd[6] = trig_r;
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            wb_ack_r <= 1'b0;
            wb_dat_r <= 32'h0000_0000;
        end else begin
            wb_ack_r <= bus_req;
            if (bus_req && !wb_we_in) begin
                case (wb_adr_in)
                    ICU_OFS_CTRL_ONE: wb_dat_r <= {16'h0000, ctrl_one_rd};
                    ICU_OFS_CTRL_TWO: wb_dat_r <= {16'h0000, ctrl_two_rd};
                    ICU_OFS_FIFO: wb_dat_r <= {16'h0000, fifo_mem_r[rd_ptr_r]}; // RULE_22
                    ICU_OFS_COUNTER: wb_dat_r <= {16'h0000, counter_r};
                    default: wb_dat_r <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Control registers; status bits are kept separately
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            ctrl_one_r <= icu_ctrl_one_t'(ICU_CTRL_ONE_RESET);
            ctrl_two_r <= icu_ctrl_two_t'(ICU_CTRL_TWO_RESET);
        end else begin
            if (wr_ctrl_one) begin
                ctrl_one_r <= icu_ctrl_one_t'((ctrl_one_r & ~(wmask & ICU_CTRL_ONE_WMASK))
                    | (wb_dat_in[15:0] & wmask & ICU_CTRL_ONE_WMASK));
            end
            if (wr_ctrl_two) begin
                ctrl_two_r <= icu_ctrl_two_t'((ctrl_two_r & ~(wmask & ICU_CTRL_TWO_WMASK))
                    | (wb_dat_in[15:0] & wmask & ICU_CTRL_TWO_WMASK));
            end
        end
    end

    // Trigger status: hardware trigger or software write sets, software write clears
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            trig_r <= 1'b0;
        end else if (trig_mode && src_event) begin
            trig_r <= 1'b1; // RULE_13
        end else if (wr_ctrl_two && wb_sel_in[0]) begin
            trig_r <= wb_dat_in[6]; // RULE_13 RULE_25
        end
    end

    // Synchronous channel stays cleared until its source first fires
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            sync_seen_r <= 1'b0;
        end else if (!sync_mode || !active) begin
            sync_seen_r <= 1'b0; // RULE_18
        end else if (src_event) begin
            sync_seen_r <= 1'b1; // RULE_18
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            counter_r <= 16'h0000;
        end else if (hold_clear || sync_reset || !active) begin
            counter_r <= 16'h0000; // RULE_13 RULE_24
        end else if (count_en) begin
            counter_r <= counter_r + 16'h0001; // RULE_23
        end
    end

    // Edge history and prescaler; prescaler restarts whenever the mode stops it
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            pin_prev_r <= 1'b0;
            presc_r <= 4'h0;
        end else begin
            pin_prev_r <= capture_input_pin;
            if (!active || hold_clear) begin
                presc_r <= 4'h0;
            end else if (rise) begin
                presc_r <= presc_r + 4'h1; // RULE_02
            end
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            irq_cnt_r <= 2'b00;
            irq_r <= 1'b0;
        end else begin
            irq_r <= irq_fire;
            if (!active) begin
                irq_cnt_r <= 2'b00;
            end else if (irq_fire) begin
                irq_cnt_r <= 2'b00; // RULE_05
            end else if (capture) begin
                irq_cnt_r <= irq_cnt_r + 2'b01; // RULE_05
            end
        end
    end

    // Wake-only mode: rising edge while asleep or idle
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            wake_r <= 1'b0;
        end else begin
            wake_r <= (mode == ICU_MODE_WAKE) & rise & (cpu_sleep_in | cpu_idle_in); // RULE_04
        end
    end

    // FIFO storage; a full FIFO drops the new value and keeps the old ones
    always_ff @(posedge clk_in) begin
        if (push) begin
            fifo_mem_r[wr_ptr_r] <= counter_r; // RULE_23 RULE_27
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            fill_r <= '0;
        end else begin
            if (push) begin
                wr_ptr_r <= wr_ptr_r + ICU_PTR_W'(1);
            end
            if (pop) begin
                rd_ptr_r <= rd_ptr_r + ICU_PTR_W'(1); // RULE_07
            end
            case ({push, pop})
                2'b10: fill_r <= fill_r + (ICU_PTR_W+1)'(1);
                2'b01: fill_r <= fill_r - (ICU_PTR_W+1)'(1);
                default: fill_r <= fill_r;
            endcase
        end
    end

    // Overflow sticks until the channel is turned off
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            ovf_r <= 1'b0;
        end else if (capture && fifo_full) begin
            ovf_r <= 1'b1; // RULE_08 RULE_27
        end else if (mode == ICU_MODE_OFF) begin
            ovf_r <= 1'b0; // RULE_27
        end
    end

    assign wb_ack_out = wb_ack_r;
    assign wb_dat_out = wb_dat_r;
    assign capture_irq_out = irq_r;
    assign wake_out = wake_r;
    assign pair_out.cascade_enable = ctrl_two_r.cascade_enable; // RULE_11
    assign pair_out.capture = capture; // RULE_22
    assign pair_out.wrap = wrap; // RULE_26
    assign pair_out.counter_clear = hold_clear | sync_reset | ~active; // RULE_20

endmodule
`default_nettype wire

// ---- verif/icu_input_capture_unit_assertions.sv ----
// Port checker for the input capture unit
`timescale 1ns/1ps
`default_nettype none
module icu_input_capture_unit_assertions
    import icu_pkg::*;
(
    input wire logic clk_in, // Clock
    input wire logic rst_b_in, // Reset
    input wire logic wb_cyc_in, // Cycle
    input wire logic wb_stb_in, // Strobe
    input wire logic wb_we_in, // Write
    input wire logic [ICU_ADDR_W-1:0] wb_adr_in, // Address
    input wire logic [31:0] wb_dat_out, // Read data
    input wire logic wb_ack_out, // Acknowledge
    input wire logic capture_input_pin, // Pin
    input wire logic cpu_idle_in, // Idle
    input wire logic cpu_sleep_in, // Sleep
    input wire logic capture_irq_out, // Interrupt
    input wire logic wake_out // Wake
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);
    property p_ack_answer;
        wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out;
    endproperty
    a_ack_answer: assert property (p_ack_answer) else $error("no ack after request");
    property p_ack_pulse;
        wb_ack_out |=> !wb_ack_out;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
    property p_upper_zero;
        wb_ack_out |-> wb_dat_out[31:16] == 16'h0000;
    endproperty
    a_upper_zero: assert property (p_upper_zero) else $error("upper read bits not zero");
    property p_unmapped;
        wb_ack_out && !wb_we_in && wb_adr_in[1:0] != 2'h0 |-> wb_dat_out == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    // Bits 15:14 and 9:7 of control one have no storage
    property p_one_rsvd;
        wb_ack_out && !wb_we_in && wb_adr_in == ICU_OFS_CTRL_ONE |-> (wb_dat_out & 32'hC380) == 0;
    endproperty
    a_one_rsvd: assert property (p_one_rsvd) else $error("reserved bits read set");
    property p_wake_asleep;
        wake_out |-> $past(cpu_sleep_in || cpu_idle_in);
    endproperty
    a_wake_asleep: assert property (p_wake_asleep) else $error("wake while awake");
    property p_wake_pin;
        wake_out |-> $past(capture_input_pin);
    endproperty
    a_wake_pin: assert property (p_wake_pin) else $error("wake without high pin");
    property p_irq_pulse;
        capture_irq_out |=> !capture_irq_out;
    endproperty
    a_irq_pulse: assert property (p_irq_pulse) else $error("irq longer than a pulse");
endmodule
bind icu_input_capture_unit icu_input_capture_unit_assertions i_chk (.clk_in(clk_in),
    .rst_b_in(rst_b_in), .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in),
    .wb_adr_in(wb_adr_in), .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out),
    .capture_input_pin(capture_input_pin), .cpu_idle_in(cpu_idle_in),
    .cpu_sleep_in(cpu_sleep_in), .capture_irq_out(capture_irq_out), .wake_out(wake_out));
`default_nettype wire

// ---- verif/icu_pulse_source.sv ----
// External pulse source driving the capture pin
`timescale 1ns/1ps
`default_nettype none
module icu_pulse_source (
    input wire logic clk_in, // Clock
    input wire logic rst_b_in, // Reset, active low
    input wire logic go_in, // Start a train
    input wire logic [7:0] count_in, // Pulses in the train
    output logic pin_out, // Pin level
    output logic busy_out // Train running
);
    logic [7:0] left_r;
    logic [2:0] phase_r;
    // Four high, four low
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            left_r <= 8'h00;
            phase_r <= 3'h0;
        end else if (go_in) begin
            left_r <= count_in;
            phase_r <= 3'h0;
        end else if (left_r != 8'h00) begin
            phase_r <= phase_r + 3'h1;
            if (phase_r == 3'h7) left_r <= left_r - 8'h01;
        end
    end
    assign pin_out = (left_r != 8'h00) && !phase_r[2];
    assign busy_out = left_r != 8'h00;
endmodule
`default_nettype wire

// ---- verif/icu_input_capture_unit_test.sv ----
// Self-checking bench of the input capture unit
`timescale 1ns/1ps
`default_nettype none
module icu_input_capture_unit_test;
    import icu_pkg::*;
    typedef struct packed {
        logic [2:0] mode;
        logic [1:0] rate;
        logic halt;
        logic idle;
        logic [7:0] pulses;
        logic [7:0] caps;
        logic [7:0] irqs;
        logic ovf;
    } icu_row_t;
    localparam int ROWS = 15;
    // mode rate halt idle pulses captures irqs overflow
    localparam icu_row_t TABLE [ROWS] = '{
        '{3'h3, 2'h0, 1'h0, 1'h0, 8'h03, 8'h03, 8'h03, 1'h0}, '{3'h2, 2'h0, 1'h0, 1'h0, 8'h03, 8'h03, 8'h03, 1'h0},
        '{3'h1, 2'h3, 1'h0, 1'h0, 8'h02, 8'h04, 8'h04, 1'h0}, '{3'h4, 2'h0, 1'h0, 1'h0, 8'h08, 8'h02, 8'h02, 1'h0},
        '{3'h5, 2'h0, 1'h0, 1'h0, 8'h10, 8'h01, 8'h01, 1'h0}, '{3'h0, 2'h0, 1'h0, 1'h0, 8'h03, 8'h00, 8'h00, 1'h0},
        '{3'h6, 2'h0, 1'h0, 1'h0, 8'h03, 8'h00, 8'h00, 1'h0}, '{3'h7, 2'h0, 1'h0, 1'h0, 8'h03, 8'h00, 8'h00, 1'h0},
        '{3'h7, 2'h0, 1'h0, 1'h1, 8'h03, 8'h00, 8'h00, 1'h0}, '{3'h3, 2'h1, 1'h0, 1'h0, 8'h04, 8'h04, 8'h02, 1'h0},
        '{3'h3, 2'h2, 1'h0, 1'h0, 8'h03, 8'h03, 8'h01, 1'h0}, '{3'h3, 2'h3, 1'h0, 1'h0, 8'h04, 8'h04, 8'h01, 1'h0},
        '{3'h3, 2'h0, 1'h1, 1'h1, 8'h03, 8'h00, 8'h00, 1'h0}, '{3'h3, 2'h0, 1'h0, 1'h1, 8'h03, 8'h03, 8'h03, 1'h0},
        '{3'h3, 2'h3, 1'h0, 1'h0, 8'h05, 8'h04, 8'h01, 1'h1}};
    logic clk_in = 1'b0;
    logic rst_b_in = 1'b0;
    logic wb_cyc_in = 1'b0;
    logic wb_stb_in = 1'b0;
    logic wb_we_in = 1'b0;
    logic [ICU_ADDR_W-1:0] wb_adr_in = '0;
    logic [3:0] wb_sel_in = 4'h0;
    logic [31:0] wb_dat_in = 32'h0;
    logic [31:0] wb_dat_out;
    logic wb_ack_out;
    logic cpu_idle_in = 1'b0;
    logic go_r = 1'b0;
    logic [7:0] count_r = 8'h00;
    logic pin;
    logic busy;
    logic irq;
    logic wake;
    int irq_n = 0;
    int wake_n = 0;
    int errors = 0;
    int checks = 0;
    int cycles = 0;
    icu_input_capture_unit i_dut (.clk_in(clk_in), .rst_b_in(rst_b_in), .wb_cyc_in(wb_cyc_in),
        .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in), .wb_sel_in(wb_sel_in),
        .wb_dat_in(wb_dat_in), .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out),
        .capture_input_pin(pin), .timebase_tick_in(5'h00), .sync_events_in(32'h0),
        .cpu_idle_in(cpu_idle_in), .cpu_sleep_in(1'b0), .upper_half_in(1'b0), .pair_in('0),
        .pair_out(), .capture_irq_out(irq), .wake_out(wake));
    icu_pulse_source i_src (.clk_in(clk_in), .rst_b_in(rst_b_in), .go_in(go_r),
        .count_in(count_r), .pin_out(pin), .busy_out(busy));
    always #5 clk_in = ~clk_in;
    always @(posedge clk_in) begin
        if (irq === 1'b1) irq_n <= irq_n + 1;
        if (wake === 1'b1) wake_n <= wake_n + 1;
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            errors++;
            stop_test();
        end
    end
    task automatic stop_test();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        checks++;
        if (seen !== want) begin
            errors++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, want);
        end
    endtask
    task automatic wb_cycle(input logic we, input logic [ICU_ADDR_W-1:0] a,
            input logic [15:0] w, output logic [15:0] r);
        int t;
        @(posedge clk_in);
        wb_cyc_in <= 1'b1;
        wb_stb_in <= 1'b1;
        wb_we_in <= we;
        wb_adr_in <= a;
        wb_sel_in <= 4'h3;
        wb_dat_in <= {16'h0000, w};
        t = 0;
        do begin
            @(posedge clk_in);
            t++;
        end while (wb_ack_out !== 1'b1 && t < 40);
        r = wb_dat_out[15:0];
        wb_cyc_in <= 1'b0;
        wb_stb_in <= 1'b0;
        if (t == 40) errors++;
    endtask
    task automatic fire(input logic [7:0] count);
        int t;
        @(posedge clk_in);
        go_r <= 1'b1;
        count_r <= count;
        @(posedge clk_in);
        go_r <= 1'b0;
        t = 0;
        do begin
            @(posedge clk_in);
            t++;
        end while (busy === 1'b1 && t < 300);
        repeat (4) @(posedge clk_in);
    endtask
    // Pops until empty; keeps first two stamps
    task automatic drain(output int n, output logic [15:0] f0, output logic [15:0] f1);
        logic [15:0] d;
        n = 0;
        f0 = 16'h0000;
        f1 = 16'h0000;
        for (int k = 0; k < 8; k++) begin
            wb_cycle(1'b0, ICU_OFS_CTRL_ONE, 16'h0000, d);
            if (d[3] !== 1'b1) break;
            wb_cycle(1'b0, ICU_OFS_FIFO, 16'h0000, d);
            if (n == 0) f0 = d;
            if (n == 1) f1 = d;
            n++;
        end
    endtask
    task automatic run_row(input icu_row_t r);
        logic [15:0] d;
        logic [15:0] cfg;
        logic [15:0] f0;
        logic [15:0] f1;
        int n;
        int irq0;
        int wake0;
        cfg = {2'h0, r.halt, 3'h7, 3'h0, r.rate, 2'h0, r.mode};
        wb_cycle(1'b1, ICU_OFS_CTRL_ONE, 16'h0000, d);
        wb_cycle(1'b0, ICU_OFS_CTRL_ONE, 16'h0000, d);
        check(d, 16'h0000);
        wb_cycle(1'b1, ICU_OFS_CTRL_TWO, 16'h0000, d);
        wb_cycle(1'b1, ICU_OFS_CTRL_ONE, cfg | 16'h0018, d);
        wb_cycle(1'b0, ICU_OFS_CTRL_ONE, 16'h0000, d);
        check(d, cfg);
        cpu_idle_in <= r.idle;
        irq0 = irq_n;
        wake0 = wake_n;
        fire(r.pulses);
        if (r.mode != 3'h7) check(16'(irq_n - irq0), {8'h00, r.irqs});
        check(16'(wake_n - wake0), (r.mode == 3'h7 && r.idle) ? {8'h00, r.pulses} : 16'h0);
        wb_cycle(1'b0, ICU_OFS_CTRL_ONE, 16'h0000, d);
        check(d, cfg | {11'h0, r.ovf, r.caps != 8'h00, 3'h0});
        drain(n, f0, f1);
        check(16'(n), {8'h00, r.caps});
        // One tick a clock
        if (n >= 2) check(f1 - f0, r.mode == 3'h1 ? 16'h4 : r.mode == 3'h4 ? 16'h20 : 16'h8);
        cpu_idle_in <= 1'b0;
    endtask
    initial begin
        logic [15:0] d;
        logic [15:0] f0;
        logic [15:0] f1;
        int n;
        repeat (2) @(posedge clk_in);
        rst_b_in <= 1'b1;
        wb_cycle(1'b0, ICU_OFS_CTRL_ONE, 16'h0000, d);
        check(d, 16'h0000);
        wb_cycle(1'b0, ICU_OFS_CTRL_TWO, 16'h0000, d);
        check(d, 16'h000D);
        wb_cycle(1'b0, 4'h2, 16'h0000, d);
        check(d, 16'h0000);
        for (int i = 0; i < ROWS; i++) run_row(TABLE[i]);
        wb_cycle(1'b1, ICU_OFS_CTRL_ONE, 16'h0000, d);
        drain(n, f0, f1);
        wb_cycle(1'b1, ICU_OFS_CTRL_TWO, 16'h0080, d);
        wb_cycle(1'b1, ICU_OFS_CTRL_ONE, 16'h1C03, d);
        fire(8'h02);
        drain(n, f0, f1);
        check(16'(n), 16'h0000);
        wb_cycle(1'b1, ICU_OFS_CTRL_TWO, 16'h00C0, d);
        wb_cycle(1'b0, ICU_OFS_CTRL_TWO, 16'h0000, d);
        check(d, 16'h00C0);
        fire(8'h02);
        drain(n, f0, f1);
        check(16'(n), 16'h0002);
        // Mid-run reset
        @(posedge clk_in);
        rst_b_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        rst_b_in <= 1'b1;
        wb_cycle(1'b0, ICU_OFS_CTRL_TWO, 16'h0000, d);
        check(d, 16'h000D);
        stop_test();
    end
endmodule
`default_nettype wire
